//--- design/eep_pkg.sv
// constants and types shared by the eeprom serial front end
package eep_pkg;

  // ---------------------------------------------------------------
  // clock and self-timed intervals
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ                  = 10_000_000;
  localparam int unsigned WRITE_CYCLE_TIME_MS     = 5;   // longest write_cycle_time
  localparam int unsigned WRITE_CYCLE_CYCLES      = WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned POWER_UP_READ_DELAY_MS  = 1;   // power_up_read_delay the host waits
  localparam int unsigned POWER_UP_READ_CYCLES    = POWER_UP_READ_DELAY_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PROTECT_PIN_ENABLE_POS  = 7;   // protect_pin_enable_bit in status byte
  localparam int unsigned BYTE_BITS               = 8;
  localparam logic [2:0]  BIT_CNT_RST             = 3'h0;
  localparam logic [2:0]  BIT_CNT_LAST            = 3'h7;
  localparam logic [7:0]  BYTE_RST                = 8'h00;

  // frame state, one-hot
  typedef enum logic [2:0] {
    EEP_IDLE   = 3'b001,
    EEP_ACTIVE = 3'b010,
    EEP_PAUSED = 3'b100
  } eep_state_e;

endpackage : eep_pkg

//--- design/eep_write_timer.sv
// self-timed write cycle counter
module eep_write_timer
  import eep_pkg::*;
#(
  parameter int unsigned CYCLES = WRITE_CYCLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          busy;
    logic          done;
  } eep_tmr_s;

  eep_tmr_s tmr_reg;
  eep_tmr_s tmr_next;

  // ---------------------------------------------------------------
  // countdown; a start while busy is ignored so a cycle never stretches
  // ---------------------------------------------------------------
  always_comb begin
    tmr_next      = tmr_reg;
    tmr_next.done = 1'b0;
    if (tmr_reg.busy) begin
      if (tmr_reg.cnt == '0) begin
        tmr_next.busy = 1'b0;
        tmr_next.done = 1'b1;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - 1'b1;
      end
    end else if (start) begin
      tmr_next.busy = 1'b1;
      tmr_next.cnt  = CW'(CYCLES - 1);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign busy = tmr_reg.busy;
  assign done = tmr_reg.done;

  start_busy_a: assert property (@(posedge clk) disable iff (rst)
    start && !busy |=> busy) else $error("write timer did not start");
  done_end_a: assert property (@(posedge clk) disable iff (rst)
    done |-> !busy && $past(busy)) else $error("done without a finished cycle");

endmodule : eep_write_timer

//--- design/eep_front.sv
// serial pin front end: framing, shifting, pause, write protect, write timer
// Functional notes
// - sample serial input on sck rising edge
// - change serial output on sck falling edge
// - chip select high: output off, standby once no write cycle is running
// - protect pin high imposes no write restriction
// - pin low and enable set: reject status writes
// - pause low suspends transfer, state kept
// - self-timed write ends within write cycle time
// - enable bit seven gates the protect pin
module eep_front
  import eep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       hold_n,
  input  wire logic       wp_n,
  output logic            so_out,
  output logic            so_oe,
  input  wire logic [7:0] tx_data,
  input  wire logic [7:0] status_byte,
  input  wire logic       write_armed,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            tx_load,
  output logic            frame_open,
  output logic            frame_close,
  output logic            status_write_allowed,
  output logic            write_busy,
  output logic            write_done,
  output logic            standby
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    eep_state_e state;
    logic       sck_prev;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic [7:0] tx_shift;
    logic       so;
    logic       any_byte;
    logic       tx_load;
    logic       frame_open;
    logic       frame_close;
  } eep_front_s;

  eep_front_s fr_reg;
  eep_front_s fr_next;
  logic       sck_rise;
  logic       sck_fall;
  logic       write_start;

  // edges of sck as seen against the last sample
  assign sck_rise = sck & ~fr_reg.sck_prev;
  assign sck_fall = ~sck & fr_reg.sck_prev;

  // ---------------------------------------------------------------
  // frame and shift logic
  // ---------------------------------------------------------------
  always_comb begin
    fr_next             = fr_reg;
    fr_next.sck_prev    = sck;  // tracked even when paused so no stale edge appears on resume
    fr_next.rx_valid    = 1'b0;
    fr_next.tx_load     = 1'b0;
    fr_next.frame_open  = 1'b0;
    fr_next.frame_close = 1'b0;
    case (fr_reg.state)
      EEP_IDLE: begin
        if (!cs_n) begin
          fr_next.state      = hold_n ? EEP_ACTIVE : EEP_PAUSED;
          fr_next.frame_open = 1'b1;
          fr_next.bit_cnt    = BIT_CNT_RST;
          fr_next.any_byte   = 1'b0;
          fr_next.so         = 1'b0;
        end
      end
      EEP_ACTIVE: begin
        if (cs_n) begin
          fr_next.state       = EEP_IDLE;
          fr_next.frame_close = 1'b1;
        end else if (!hold_n) begin
          fr_next.state = EEP_PAUSED;
        end else begin
          if (sck_rise) begin
            fr_next.rx_shift = {fr_reg.rx_shift[6:0], si};
            fr_next.bit_cnt  = fr_reg.bit_cnt + 3'h1;
            if (fr_reg.bit_cnt == BIT_CNT_LAST) begin
              fr_next.rx_data  = {fr_reg.rx_shift[6:0], si};
              fr_next.rx_valid = 1'b1;
              fr_next.any_byte = 1'b1;
            end
          end
          // mode 3 opens with a falling edge; any_byte keeps it from loading
          if (sck_fall && fr_reg.any_byte) begin
            if (fr_reg.bit_cnt == BIT_CNT_RST) begin
              fr_next.so       = tx_data[7];
              fr_next.tx_shift = {tx_data[6:0], 1'b0};
              fr_next.tx_load  = 1'b1;
            end else begin
              fr_next.so       = fr_reg.tx_shift[7];
              fr_next.tx_shift = {fr_reg.tx_shift[6:0], 1'b0};
            end
          end
        end
      end
      EEP_PAUSED: begin
        // sck and si are ignored here; counters and shifters hold
        if (cs_n) begin
          fr_next.state       = EEP_IDLE;
          fr_next.frame_close = 1'b1;
        end else if (hold_n) begin
          fr_next.state = EEP_ACTIVE;
        end
      end
      default: begin
        fr_next.state = EEP_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      fr_reg          <= '0;
      fr_reg.state    <= EEP_IDLE;
      fr_reg.rx_data  <= BYTE_RST;
      fr_reg.sck_prev <= 1'b0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  // ---------------------------------------------------------------
  // write cycle timer, started by the closing chip select edge
  // ---------------------------------------------------------------
  assign write_start = fr_reg.frame_close & write_armed;

  eep_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (write_start),
    .busy  (write_busy),
    .done  (write_done)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign so_out      = fr_reg.so;
  assign so_oe       = (fr_reg.state == EEP_ACTIVE);
  assign rx_data     = fr_reg.rx_data;
  assign rx_valid    = fr_reg.rx_valid;
  assign tx_load     = fr_reg.tx_load;
  assign frame_open  = fr_reg.frame_open;
  assign frame_close = fr_reg.frame_close;
  // a running write cycle keeps the part out of standby
  assign standby     = (fr_reg.state == EEP_IDLE) & ~write_busy;
  // pin only matters when the enable bit is set
  assign status_write_allowed = wp_n | ~status_byte[PROTECT_PIN_ENABLE_POS];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence active_rise_s;
    fr_reg.state == EEP_ACTIVE && !cs_n && hold_n && sck_rise;
  endsequence

  rx_sample_a: assert property (active_rise_s |=> fr_reg.rx_shift[0] == $past(si))
    else $error("serial input not sampled on rising edge");
  so_stable_a: assert property (fr_reg.state == EEP_ACTIVE && !sck_fall |=> $stable(so_out))
    else $error("serial output changed without falling edge");
  cs_hiz_a: assert property (cs_n |=> !so_oe)
    else $error("output driven while deselected");
  busy_standby_a: assert property (write_busy |-> !standby)
    else $error("standby during write cycle");
  wp_high_a: assert property (wp_n |-> status_write_allowed)
    else $error("status write blocked with protect pin high");
  wp_block_a: assert property (!wp_n && status_byte[7] |-> !status_write_allowed)
    else $error("status write allowed while protected");
  enable_off_a: assert property (!status_byte[7] |-> status_write_allowed)
    else $error("protect pin acted with enable clear");
  pause_keep_a: assert property (fr_reg.state == EEP_PAUSED |=> $stable(fr_reg.rx_shift) && $stable(fr_reg.bit_cnt))
    else $error("state lost while paused");
  pause_hiz_a: assert property (!hold_n |=> !so_oe [*1] ##0 $stable(fr_reg.tx_shift))
    else $error("output driven or shifted while paused");
  write_go_a: assert property (write_start && !write_busy |=> write_busy)
    else $error("write cycle did not start at frame close");

endmodule : eep_front

//--- tb/eep_host.sv
// host spi controller model driving the eeprom pins
module eep_host (
  input  wire logic clk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_lvl;

  // idle pins, deselected
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    idle_lvl = 1'b0;
  end

  // wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // sck settles at its idle level before select falls
  task automatic open_frame(input logic mode);
    idle_lvl = mode;
    sck = mode;
    tick(2);
    cs_n = 1'b0;
    tick(2);
  endtask : open_frame

  // data set while sck low, so read just before the rising edge
  task automatic put_bit(input logic b, output logic got);
    sck = 1'b0;
    si = b;
    tick(2);
    got = so_oe ? so_out : ~so_out;  // a released line reads inverted, never a stale bit
    sck = 1'b1;
    tick(2);
  endtask : put_bit

  // msb first
  task automatic put_byte(input logic [7:0] b, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) put_bit(b[i], got[i]);
  endtask : put_byte

  // si is flipped once released so a stale level never looks valid
  task automatic close_frame();
    sck = idle_lvl;
    tick(2);
    cs_n = 1'b1;
    si = ~si;
    tick(2);
  endtask : close_frame

  // sck low at both hold transitions, pause gets a stray sck pulse
  task automatic pause(input logic lvl);
    sck = 1'b0;
    tick(1);
    hold_n = lvl;
    tick(2);
    if (!lvl) begin
      sck = 1'b1;
      si = ~si;
      tick(2);
      sck = 1'b0;
      tick(2);
    end
  endtask : pause
endmodule : eep_host

//--- tb/tb_top.sv
// self-checking bench for the eeprom serial front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import eep_pkg::*;
  localparam int unsigned WC = 20;  // short write cycle keeps the run brief
  typedef struct packed {
    logic mode; logic wp; logic [7:0] st; logic [7:0] din; logic [7:0] dout; logic ok;
  } eep_row_s;
  // ok: status write permitted for this pin and enable bit pair
  localparam eep_row_s ROWS [4] = '{'{1'b0, 1'b1, 8'h80, 8'hA5, 8'h3C, 1'b1},
                                    '{1'b1, 1'b0, 8'h80, 8'h01, 8'hC3, 1'b0},
                                    '{1'b0, 1'b0, 8'h00, 8'hFF, 8'h00, 1'b1},
                                    '{1'b1, 1'b1, 8'h00, 8'h00, 8'hFF, 1'b1}};
  logic       clk, rst, wp_n, write_armed;
  logic [7:0] tx_data, status_byte, rx_data;
  int         n_open = 0, n_close = 0, n_rx = 0, n_load = 0, n_done = 0;
  logic       cs_n, sck, si, hold_n, so_out, so_oe, rx_valid, tx_load, frame_open, frame_close;
  logic       status_write_allowed, write_busy, write_done, standby;
  int         num_errors = 0, tests_run = 0;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // pulse tally, taken mid-cycle where the registered pulses have settled
  always @(negedge clk) begin
    if (!rst) begin
      n_open  += frame_open;
      n_close += frame_close;
      n_rx    += rx_valid;
      n_load  += tx_load;
      n_done  += write_done;
    end
  end

  eep_front #(.WRITE_CYCLES(WC)) u_eep_front (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .tx_data(tx_data), .status_byte(status_byte),
    .write_armed(write_armed), .rx_data(rx_data), .rx_valid(rx_valid), .tx_load(tx_load),
    .frame_open(frame_open), .frame_close(frame_close), .status_write_allowed(status_write_allowed),
    .write_busy(write_busy), .write_done(write_done), .standby(standby));
  eep_host u_eep_host (.clk(clk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));

  // ---------------------------------------------------------------
  // checking and verdict
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // watchdog sized well past the power-up wait plus the few hundred cycles of tests
  initial begin
    #5_000_000;
    num_errors++;
    final_report();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] got;
    int         n;
    rst = 1'b1;
    wp_n = 1'b1;
    write_armed = 1'b0;
    tx_data = 8'h00;
    status_byte = 8'h00;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    u_eep_host.tick(POWER_UP_READ_CYCLES);
    u_eep_host.tick(1);
    check(so_oe, 1'b0, "oe after reset");
    check(standby, 1'b1, "standby after reset");
    // table rows: both modes, every protect combination, lagged output byte
    for (int i = 0; i < 4; i++) begin
      wp_n = ROWS[i].wp;
      status_byte = ROWS[i].st;
      tx_data = ROWS[i].dout;
      #1 check(status_write_allowed, ROWS[i].ok, "protect gate");
      u_eep_host.open_frame(ROWS[i].mode);
      check(so_oe, 1'b1, "oe in frame");
      check(standby, 1'b0, "standby in frame");
      u_eep_host.put_byte(ROWS[i].din, got);
      check(rx_data, ROWS[i].din, "first byte in");
      u_eep_host.put_byte(8'h5A, got);
      check(got, ROWS[i].dout, "byte out");
      check(rx_data, 8'h5A, "second byte in");
      u_eep_host.close_frame();
      check(so_oe, 1'b0, "oe after close");
      check(standby, 1'b1, "standby after close");
      $display("row %0d done", i);
    end
    // pause in mid-byte, stray sck ignored, transfer resumes in place
    u_eep_host.open_frame(1'b0);
    tx_data = 8'h96;
    u_eep_host.put_byte(8'hC3, got);
    for (int i = 7; i >= 4; i--) u_eep_host.put_bit(i[0] ^ i[1], got[i]);
    u_eep_host.pause(1'b0);
    check(so_oe, 1'b0, "oe while paused");
    u_eep_host.pause(1'b1);
    check(so_oe, 1'b1, "oe after pause");
    for (int i = 3; i >= 0; i--) u_eep_host.put_bit(~(i[0] ^ i[1]), got[i]);
    check(rx_data, 8'h69, "byte across pause");
    check(got, 8'h96, "out byte across pause");
    write_armed = 1'b1;
    u_eep_host.close_frame();
    write_armed = 1'b0;
    $display("pause test done");
    // self-timed write runs past deselect, then ends on its count
    u_eep_host.tick(1);
    check(standby, 1'b0, "no standby while writing");
    n = 1;  // one busy cycle already seen by the standby check
    while (write_busy === 1'b1 && n < 1000) begin
      u_eep_host.tick(1);
      n++;
    end
    check(n[7:0], WC[7:0], "write cycle length");
    check(standby, 1'b1, "standby after write");
    $display("write timer test done");
    // reset in the middle of a write cycle clears timer and receive byte
    u_eep_host.open_frame(1'b0);
    u_eep_host.put_byte(8'h81, got);
    write_armed = 1'b1;
    u_eep_host.close_frame();
    write_armed = 1'b0;
    check(write_busy, 1'b1, "write before reset");
    rst = 1'b1;
    u_eep_host.tick(2);
    rst = 1'b0;
    check(write_busy, 1'b0, "busy after reset");
    check(rx_data, BYTE_RST, "rx after reset");
    check(standby, 1'b1, "standby after mid reset");
    u_eep_host.tick(WC + 2);
    $display("mid-run reset test done");
    // six frames, eleven bytes in, nine output loads, one finished write
    check(n_open[7:0], 8'h06, "frame open count");
    check(n_close[7:0], 8'h06, "frame close count");
    check(n_rx[7:0], 8'h0B, "receive pulse count");
    check(n_load[7:0], 8'h09, "load pulse count");
    check(n_done[7:0], 8'h01, "write done count");
    final_report();
  end
endmodule : tb_top
